/* File: epac_pkg.sv */
// constants for the eprom read access control block
package epac_pkg;
  localparam logic [15:0] EPAC_CTRL_ADDR = 16'h0007;
  localparam logic [15:0] EPAC_MISC_ADDR = 16'h000c;
  localparam logic [15:0] EPAC_OPTS_ADDR = 16'h0100;
  localparam logic [15:0] EPAC_FOB_ADDR = 16'h7fde;
  localparam logic [15:0] EPAC_MAIN_LO = 16'h0400;
  localparam logic [15:0] EPAC_MAIN_HI = 16'h7dff;
  localparam logic [15:0] EPAC_VEC_LO = 16'h7ff0;
  localparam logic [15:0] EPAC_VEC_HI = 16'h7fff;
  localparam logic [15:0] EPAC_BOOT_LO = 16'h7e00;
  localparam logic [15:0] EPAC_BOOT_HI = 16'h7fdd;
  localparam int EPAC_LAT_BIT = 5;
  localparam int EPAC_PGM_BIT = 4;
  localparam int EPAC_POR_BIT = 7;
  localparam int EPAC_WATCHDOG_ENABLE_FLAG_BIT = 0;
  localparam logic [7:0] EPAC_CTRL_RST = 8'h00;
  localparam logic [7:0] EPAC_MISC_RST = 8'h10;
  localparam logic [7:0] EPAC_ERASED = 8'h00;
  localparam logic [7:0] EPAC_SCRAMBLE = 8'ha5;
  localparam logic [7:0] EPAC_CTRL_WMASK = 8'hcf;
  localparam logic [7:0] EPAC_MISC_WMASK = 8'h7e;
  typedef enum logic [2:0] {
    EPAC_SEL_NONE = 3'h1,
    EPAC_SEL_ARRAY = 3'h2,
    EPAC_SEL_VEC = 3'h4
  } epac_sel_e;
endpackage

/* File: epac_sync.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module epac_sync (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: epac_core.sv */
// eprom read access control: decode, latch gating and status registers
`timescale 1ns/1ps
`default_nettype none
module epac_core
  import epac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic watchdog_enable_flag_option,
  input wire logic stop_entry,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_vec,
  input wire logic cpu_boot,
  input wire logic [7:0] array_data,
  input wire logic array_blank,
  input wire logic [7:0] opts_data,
  input wire logic [7:0] fob_data,
  output logic [7:0] cpu_rdata,
  output logic cpu_valid,
  output logic vec_fault,
  output logic boot_block,
  output logic eprom_read_mode,
  output logic eprom_latch_enable,
  output logic eprom_program_enable,
  output logic array_wr
);
  ////////////////////////////////////////////////////////////////
  // decode
  logic por_seen;
  logic watchdog_enable_flag_sync;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] misc_r;
  logic [7:0] misc_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] crd_nxt;
  logic cvalid_nxt;
  logic wrote_r;
  logic wrote_nxt;
  logic in_main;
  logic in_vec;
  logic in_fob;
  logic in_boot;
  // three loads after release so the synchronised option level has settled
  logic [2:0] rst_pend_r;
  epac_sel_e sel;

  // the option level is a pin; it is only read once settled
  epac_sync u_watchdog_enable_flag_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(watchdog_enable_flag_option),
    .dout(watchdog_enable_flag_sync)
  );

  assign in_main = cpu_addr >= EPAC_MAIN_LO && cpu_addr <= EPAC_MAIN_HI;
  assign in_vec = cpu_addr >= EPAC_VEC_LO && cpu_addr <= EPAC_VEC_HI;
  assign in_fob = cpu_addr == EPAC_FOB_ADDR;
  assign in_boot = cpu_boot && cpu_addr >= EPAC_BOOT_LO && cpu_addr <= EPAC_BOOT_HI;

  always_comb begin
    if (in_vec || cpu_vec) sel = EPAC_SEL_VEC;
    else if (in_main || in_fob) sel = EPAC_SEL_ARRAY;
    else sel = EPAC_SEL_NONE;
  end

  assign eprom_latch_enable = ctrl_r[EPAC_LAT_BIT];
  assign eprom_program_enable = ctrl_r[EPAC_PGM_BIT];
  assign eprom_read_mode = !ctrl_r[EPAC_LAT_BIT];
  // array write strobe tied low, so nothing writes the array latches; no erase command exists
  assign array_wr = 1'b0;
  assign vec_fault = cpu_vec && eprom_latch_enable;
  assign boot_block = cpu_boot && eprom_latch_enable;

  ////////////////////////////////////////////////////////////////
  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    wrote_nxt = wrote_r;
    if (reg_wr && reg_addr == EPAC_CTRL_ADDR) begin
      ctrl_nxt = (ctrl_r & ~EPAC_CTRL_WMASK) | (reg_wdata & EPAC_CTRL_WMASK);
      ctrl_nxt[EPAC_LAT_BIT] = reg_wdata[EPAC_LAT_BIT];
      // program enable may only rise after a byte was latched
      ctrl_nxt[EPAC_PGM_BIT] = ctrl_r[EPAC_PGM_BIT] | (reg_wdata[EPAC_PGM_BIT] & wrote_r);
    end
    if (reg_wr && (reg_addr >= EPAC_MAIN_LO && reg_addr <= EPAC_VEC_HI) && ctrl_r[EPAC_LAT_BIT]) begin
      wrote_nxt = 1'b1;
    end
    if (stop_entry) begin
      ctrl_nxt[EPAC_LAT_BIT] = 1'b0;
    end
    if (!ctrl_nxt[EPAC_LAT_BIT]) begin
      ctrl_nxt[EPAC_PGM_BIT] = 1'b0;
      wrote_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= EPAC_CTRL_RST;
      wrote_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      wrote_r <= wrote_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // miscellaneous register
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) por_seen <= 1'b1;
    else if (reg_wr && reg_addr == EPAC_MISC_ADDR && !reg_wdata[EPAC_POR_BIT]) por_seen <= 1'b0;
  end

  always_comb begin
    misc_nxt = misc_r;
    if (rst_pend_r != 3'h0) begin
      misc_nxt = EPAC_MISC_RST;
      misc_nxt[EPAC_WATCHDOG_ENABLE_FLAG_BIT] = watchdog_enable_flag_sync;
    end else if (reg_wr && reg_addr == EPAC_MISC_ADDR) begin
      misc_nxt = (misc_r & ~EPAC_MISC_WMASK) | (reg_wdata & EPAC_MISC_WMASK);
    end
    misc_nxt[EPAC_POR_BIT] = por_seen;
  end

  // option captured by a clock after release, not by the reset itself
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      misc_r <= EPAC_MISC_RST;
      rst_pend_r <= 3'h7;
    end else begin
      misc_r <= misc_nxt;
      rst_pend_r <= {1'b0, rst_pend_r[2:1]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // read paths
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        EPAC_CTRL_ADDR: rdata_nxt = ctrl_r;
        EPAC_MISC_ADDR: rdata_nxt = misc_r;
        EPAC_OPTS_ADDR: rdata_nxt = opts_data;
        EPAC_FOB_ADDR: rdata_nxt = fob_data;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb begin
    crd_nxt = 8'h00;
    cvalid_nxt = 1'b0;
    if (cpu_rd) begin
      case (sel)
        EPAC_SEL_VEC, EPAC_SEL_ARRAY: begin
          cvalid_nxt = !eprom_latch_enable;
          if (eprom_latch_enable) crd_nxt = array_data ^ EPAC_SCRAMBLE;
          else if (array_blank) crd_nxt = EPAC_ERASED;
          else if (in_fob) crd_nxt = fob_data;
          else crd_nxt = array_data;
        end
        EPAC_SEL_NONE: begin
          cvalid_nxt = !in_boot || !eprom_latch_enable;
          crd_nxt = array_data;
        end
        default: begin
          cvalid_nxt = 1'b0;
          crd_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      cpu_rdata <= 8'h00;
      cpu_valid <= 1'b0;
    end else begin
      reg_rdata <= rdata_nxt;
      cpu_rdata <= crd_nxt;
      cpu_valid <= cvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  a_pgm_needs_lat: assert property (@(posedge clk_sys) disable iff (!reset_n)
    eprom_program_enable |-> eprom_latch_enable) else $error("program set without latch");
  a_stop_clears_lat: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stop_entry |=> !eprom_latch_enable) else $error("stop left latch set");
  a_stop_clears_pgm: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stop_entry |=> !eprom_program_enable) else $error("stop left program set");
  a_lat_clear_pgm: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(eprom_latch_enable) |-> !eprom_program_enable) else $error("program stayed");
  a_lat_scramble: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cpu_rd && in_main && eprom_latch_enable) |=> cpu_rdata == ($past(array_data) ^ EPAC_SCRAMBLE))
    else $error("latched read not scrambled");
  a_blank_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cpu_rd && in_main && !eprom_latch_enable && array_blank) |=> cpu_rdata == EPAC_ERASED)
    else $error("blank not zero");
  a_vec_invalid: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cpu_rd && in_vec && eprom_latch_enable) |=> !cpu_valid) else $error("vector valid under latch");
  a_out_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cpu_rd && sel == EPAC_SEL_NONE && !cpu_boot) |=> cpu_valid && cpu_rdata == $past(array_data))
    else $error("outside range disturbed");
  a_ctrl_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_rd && reg_addr == EPAC_CTRL_ADDR) |=> reg_rdata == $past(ctrl_r)) else $error("ctrl read");
  c_latch_set: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(eprom_latch_enable));
  c_pgm_set: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(eprom_program_enable));
  c_stop_abort: cover property (@(posedge clk_sys) disable iff (!reset_n) stop_entry && eprom_latch_enable);
endmodule
`default_nettype wire

/* File: epac_store_model.sv */
// storage model: eprom array, options and factory option byte
`timescale 1ns/1ps
`default_nettype none
module epac_store_model (
  input wire logic [15:0] cpu_addr,
  output logic [7:0] array_data,
  output logic array_blank,
  output logic [7:0] opts_data,
  output logic [7:0] fob_data
);
  // bytes at offsets ending in f are unprogrammed
  assign array_blank = (cpu_addr[3:0] == 4'hf);
  assign array_data = array_blank ? 8'h00 : (cpu_addr[7:0] ^ 8'h3c);
  // nonvolatile: no reset reaches these
  assign opts_data = 8'h03;
  assign fob_data = 8'h5a;
endmodule
`default_nettype wire

/* File: eprom_read_access_control_bench.sv */
// self-checking bench for the eprom read access core
`timescale 1ns/1ps
`default_nettype none
module eprom_read_access_control_bench;
  import epac_pkg::*;
  logic clk_sys = 0, reset_n = 0, por_n = 0, stop_entry = 0, reg_wr = 0, reg_rd = 0;
  logic cpu_rd = 0, cpu_vec = 0, cpu_boot = 0;
  logic watchdog_enable_flag_option = 0;
  logic [15:0] reg_addr = 16'h0000, cpu_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, cpu_rdata, array_data, opts_data, fob_data;
  logic cpu_valid, vec_fault, boot_block, eprom_read_mode, eprom_latch_enable;
  logic eprom_program_enable, array_wr, array_blank;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [15:0] rd_list [5] = '{16'h0400, 16'h7dff, 16'h7ff0, 16'h7fff, 16'h040f};
  epac_core i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .por_n(por_n), .watchdog_enable_flag_option(watchdog_enable_flag_option),
    .stop_entry(stop_entry), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_vec(cpu_vec), .cpu_boot(cpu_boot), .array_data(array_data), .array_blank(array_blank),
    .opts_data(opts_data), .fob_data(fob_data), .cpu_rdata(cpu_rdata), .cpu_valid(cpu_valid),
    .vec_fault(vec_fault), .boot_block(boot_block), .eprom_read_mode(eprom_read_mode),
    .eprom_latch_enable(eprom_latch_enable), .eprom_program_enable(eprom_program_enable),
    .array_wr(array_wr));
  epac_store_model i_store (.cpu_addr(cpu_addr), .array_data(array_data),
    .array_blank(array_blank), .opts_data(opts_data), .fob_data(fob_data));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [7:0] ea(input logic [15:0] a);
    return (a[3:0] == 4'hf) ? EPAC_ERASED : (a[7:0] ^ 8'h3c);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  // f: latch expected set, so vector and boot fetches are flagged
  task automatic cr(input logic [15:0] a, input logic v, input logic b, input logic [7:0] exp,
    input logic ev, input logic f, input logic cd);
    @(posedge clk_sys);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    cpu_vec <= v;
    cpu_boot <= b;
    #1 check("faults", {6'h00, vec_fault, boot_block}, {6'h00, v & f, b & f});
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    cpu_vec <= 1'b0;
    cpu_boot <= 1'b0;
    #1 check("cpu_valid", {7'h00, cpu_valid}, {7'h00, ev});
    if (cd) check("cpu_rdata", cpu_rdata, exp);
  endtask
  task automatic fl(input logic [2:0] exp);
    #1 check("lat_pgm_mode", {5'h00, eprom_latch_enable, eprom_program_enable, eprom_read_mode}, {5'h00, exp});
    check("array_wr", {7'h00, array_wr}, 8'h00);
  endtask
  task automatic rst(input logic p);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    por_n <= ~p;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(EPAC_CTRL_ADDR, EPAC_CTRL_RST);
    rd(EPAC_MISC_ADDR, 8'h90);
    wr(EPAC_MISC_ADDR, 8'h00);
    rd(EPAC_MISC_ADDR, 8'h00);
    rd(16'h0055, 8'h00);
    watchdog_enable_flag_option <= 1'b1;
    rst(1'b0);
    rd(EPAC_MISC_ADDR, 8'h11);
    watchdog_enable_flag_option <= 1'b0;
    rst(1'b1);
    rd(EPAC_MISC_ADDR, 8'h90);
    $display("test reset done");
    foreach (rd_list[i]) cr(rd_list[i], rd_list[i][15:4] == 12'h7ff, 1'b0, ea(rd_list[i]), 1'b1, 1'b0, 1'b1);
    cr(EPAC_FOB_ADDR, 1'b0, 1'b0, 8'h5a, 1'b1, 1'b0, 1'b1);
    cr(EPAC_OPTS_ADDR, 1'b0, 1'b0, ea(EPAC_OPTS_ADDR), 1'b1, 1'b0, 1'b1);
    rd(EPAC_OPTS_ADDR, 8'h03);
    rd(EPAC_FOB_ADDR, 8'h5a);
    $display("test decode done");
    wr(EPAC_CTRL_ADDR, 8'h20);
    rd(EPAC_CTRL_ADDR, 8'h20);
    fl(3'b100);
    cr(16'h0401, 1'b0, 1'b0, ea(16'h0401) ^ EPAC_SCRAMBLE, 1'b0, 1'b1, 1'b1);
    cr(16'h7ff2, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
    cr(EPAC_BOOT_LO, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1, 1'b0);
    cr(EPAC_OPTS_ADDR, 1'b0, 1'b0, ea(EPAC_OPTS_ADDR), 1'b1, 1'b1, 1'b1);
    $display("test latched reads done");
    wr(EPAC_CTRL_ADDR, 8'h30);
    fl(3'b100);
    wr(16'h0400, 8'h11);
    wr(EPAC_CTRL_ADDR, 8'h30);
    fl(3'b110);
    wr(EPAC_CTRL_ADDR, 8'h20);
    fl(3'b110);
    wr(EPAC_CTRL_ADDR, 8'h00);
    fl(3'b001);
    cr(16'h0401, 1'b0, 1'b0, ea(16'h0401), 1'b1, 1'b0, 1'b1);
    wr(EPAC_CTRL_ADDR, 8'h10);
    fl(3'b001);
    $display("test program enable done");
    wr(EPAC_CTRL_ADDR, 8'h20);
    wr(16'h0410, 8'h22);
    wr(EPAC_CTRL_ADDR, 8'h30);
    fl(3'b110);
    @(posedge clk_sys);
    stop_entry <= 1'b1;
    @(posedge clk_sys);
    stop_entry <= 1'b0;
    fl(3'b001);
    wr(EPAC_CTRL_ADDR, 8'h20);
    rst(1'b0);
    fl(3'b001);
    $display("test stop and reset done");
    complete_run();
  end
endmodule
`default_nettype wire
